// file: common/iqu_defines.vh
// Constants for the I/Q sample unpacker: formats, scaling, sizes, timing.
// Assumes a single 100 MHz core clock; included by bare name.
`ifndef IQU_DEFINES_VH
`define IQU_DEFINES_VH

// Byte assembly states
`define IQU_ST_IHI        2'h0
`define IQU_ST_ILO        2'h1
`define IQU_ST_QHI        2'h2
`define IQU_ST_QLO        2'h3

// Legacy unsigned word: 14-bit value, two marker bits on top
`define IQU_LEG_VAL_MSB   13
`define IQU_LEG_MK_LO     14
`define IQU_LEG_MK_HI     15
`define IQU_LEG_ZERO      14'h2000
`define IQU_LEG_SHIFT     2

// Signed DAC code limits
`define IQU_CODE_MAX      16'h7fff
`define IQU_CODE_MIN      16'h8000

// Amplitude scale, percent of full scale
`define IQU_SCALE_DEF     7'h46
`define IQU_SCALE_MAX     7'h64
`define IQU_GAIN_PER_PCT  16'h0148
`define IQU_GAIN_SHIFT    15

// Interpolator taps and result shift
`define IQU_TAP_NEAR      20'h00009
`define IQU_INTERP_SHIFT  4

// Download length and FIFO shape
`define IQU_MIN_POINTS    16'h003c
`define IQU_FIFO_WIDTH    40
`define IQU_FIFO_DEPTH    32
`define IQU_FIFO_AW       5

// Marker byte: low nibble used, high nibble reserved zero
`define IQU_MK_RSVD       4'h0

// DAC word period: core clock 10 ns, sample period in ns
`define IQU_CLK_NS        10
`define IQU_SAMPLE_NS     40
`define IQU_DIV_CYCLES    ((`IQU_SAMPLE_NS) / (`IQU_CLK_NS))
`define IQU_DIV_W         8

`endif

// file: src/iqu_fifo.v
// Synchronous FIFO with a registered read port, valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module iqu_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             reset,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            load;

  // Output register adds one slot beyond DEPTH
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push     = in_valid && in_ready;
  assign load     = (!out_valid || out_ready) && (cnt_q != {(AW+1){1'b0}});

  always @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_q      <= {AW{1'b0}};
      rd_q      <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (load)
      begin
        out_data  <= mem[rd_q];
        rd_q      <= rd_q + 1'b1;
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
      if (push && !load)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (load && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // iqu_fifo

`default_nettype wire

// file: src/iqu_unpacker.v
// I/Q sample unpacker: byte stream in, scaled and interpolated DAC words out.
// Assumes byte and control inputs come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "iqu_defines.vh"

module iqu_unpacker (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // Format selection
  input  wire        legacy_fmt,
  input  wire        split_streams,
  // Main byte stream (interleaved, or I entries when split)
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [7:0]  in_byte,
  input  wire        in_last,
  input  wire [7:0]  wave_name,
  // Second byte stream (Q entries when split)
  input  wire        q_valid,
  output wire        q_ready,
  input  wire [7:0]  q_byte,
  // Settings and run-time scaling
  input  wire        set_valid,
  input  wire [6:0]  runtime_amplitude_scale,
  // Playback control
  input  wire        arbitrary_waveform_playback,
  input  wire        overload_clear,
  // DAC side
  output reg         dac_valid_q,
  output reg  [15:0] dac_i_q,
  output reg  [15:0] dac_q_q,
  output reg  [7:0]  dac_marker_q,
  // Status
  output reg         overload_q,
  output reg         short_wave_q,
  output reg         hdr_unspec_q,
  output reg  [7:0]  wave_name_q,
  output reg  [15:0] point_count_q
);

  // Saturate a 20-bit signed value to a 16-bit code
  function [16:0] sat16;
    input [19:0] v;
    begin
      if (!v[19] && (v[18:15] != 4'h0))
        sat16 = {1'b1, `IQU_CODE_MAX};
      else if (v[19] && (v[18:15] != 4'hf))
        sat16 = {1'b1, `IQU_CODE_MIN};
      else
        sat16 = {1'b0, v[15:0]};
    end
  endfunction

  // Legacy unsigned word to signed code; signed words pass unchanged
  function [15:0] to_code;
    input [15:0] w;
    input        leg;
    reg   [13:0] c;
    begin
      c = w[`IQU_LEG_VAL_MSB:0] - `IQU_LEG_ZERO;
      to_code = leg ? {c, {`IQU_LEG_SHIFT{1'b0}}} : w;
    end
  endfunction

  // Apply the amplitude scale in Q1.15
  function [16:0] scale;
    input [15:0] code;
    input [15:0] gain;
    reg   [32:0] p;
    begin
      p = $signed(code) * $signed({1'b0, gain});
      scale = sat16({{2{p[32]}}, p[32:`IQU_GAIN_SHIFT]});
    end
  endfunction

  // Four-tap midpoint interpolator: (9*(b+c) - (a+d)) / 16
  // Sum kept at 24 bits; 20 would wrap on full-scale input and hide overload
  function [19:0] interp;
    input [15:0] a;
    input [15:0] b;
    input [15:0] c;
    input [15:0] d;
    reg   [23:0] s;
    begin
      s = `IQU_TAP_NEAR * ({{8{b[15]}}, b} + {{8{c[15]}}, c})
          - {{8{a[15]}}, a} - {{8{d[15]}}, d};
      interp = s[23:`IQU_INTERP_SHIFT];
    end
  endfunction

  // Byte assembly
  reg  [1:0]  st_q;
  reg  [7:0]  hi_q;
  reg  [15:0] wi_q;
  reg  [15:0] wq_q;
  reg         pt_valid_q;
  reg         pt_last_q;
  reg         dl_active_q;
  reg         set_seen_q;
  reg  [6:0]  scale_q;
  wire        fifo_in_ready;
  wire        take_main;
  wire        take_q;
  wire        take;
  wire [7:0]  bsel;
  wire        q_phase;

  assign q_phase   = (st_q == `IQU_ST_QHI) || (st_q == `IQU_ST_QLO);
  // In split mode the Q half comes from the second stream
  assign in_ready  = !pt_valid_q && !(split_streams && q_phase);
  assign q_ready   = !pt_valid_q && split_streams && q_phase;
  assign take_main = in_valid && in_ready;
  assign take_q    = q_valid && q_ready;
  assign take      = take_main || take_q;
  assign bsel      = take_q ? q_byte : in_byte;

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      st_q       <= `IQU_ST_IHI;
      hi_q       <= 8'h00;
      wi_q       <= 16'h0000;
      wq_q       <= 16'h0000;
      pt_valid_q <= 1'b0;
      pt_last_q  <= 1'b0;
    end
    else
    begin
      if (pt_valid_q && fifo_in_ready)
      begin
        pt_valid_q <= 1'b0;
      end
      if (take)
      begin
        case (st_q)
          `IQU_ST_IHI:
          begin
            hi_q <= bsel;
            st_q <= `IQU_ST_ILO;
          end
          `IQU_ST_ILO:
          begin
            wi_q <= {hi_q, bsel};
            st_q <= `IQU_ST_QHI;
          end
          `IQU_ST_QHI:
          begin
            hi_q <= bsel;
            st_q <= `IQU_ST_QLO;
          end
          `IQU_ST_QLO:
          begin
            // Q closes the point begun by the preceding I
            wq_q       <= {hi_q, bsel};
            pt_valid_q <= 1'b1;
            pt_last_q  <= take_main && in_last;
            st_q       <= `IQU_ST_IHI;
          end
          default:
          begin
            st_q <= `IQU_ST_IHI;
          end
        endcase
      end
    end
  end

  // Conversion and scale
  wire [15:0] ci;
  wire [15:0] cq;
  wire [15:0] gain;
  wire [16:0] si;
  wire [16:0] sq;
  wire [3:0]  mk;
  wire [39:0] fifo_in;

  assign ci   = to_code(wi_q, legacy_fmt);
  assign cq   = to_code(wq_q, legacy_fmt);
  assign gain = {9'h000, scale_q} * `IQU_GAIN_PER_PCT;
  assign si   = scale(ci, gain);
  assign sq   = scale(cq, gain);
  // Legacy words carry two markers each; signed downloads get all markers off
  assign mk   = legacy_fmt ? {wq_q[`IQU_LEG_MK_HI:`IQU_LEG_MK_LO],
                              wi_q[`IQU_LEG_MK_HI:`IQU_LEG_MK_LO]} : 4'h0;
  assign fifo_in = {`IQU_MK_RSVD, mk, si[15:0], sq[15:0]};

  // Download bookkeeping
  wire first_byte;
  assign first_byte = take_main && !dl_active_q;

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      dl_active_q   <= 1'b0;
      set_seen_q    <= 1'b0;
      scale_q       <= `IQU_SCALE_DEF;
      short_wave_q  <= 1'b0;
      hdr_unspec_q  <= 1'b0;
      wave_name_q   <= 8'h00;
      point_count_q <= 16'h0000;
    end
    else
    begin
      // Name ties the point stream, its markers and its settings together
      if (first_byte)
      begin
        dl_active_q   <= 1'b1;
        wave_name_q   <= wave_name;
        point_count_q <= 16'h0000;
        set_seen_q    <= 1'b0;
        short_wave_q  <= 1'b0;
      end
      if (set_valid)
      begin
        scale_q    <= (runtime_amplitude_scale > `IQU_SCALE_MAX) ?
                      `IQU_SCALE_MAX : runtime_amplitude_scale;
        set_seen_q <= 1'b1;
      end
      // Unspecified settings leave scale_q as it stood
      if (pt_valid_q && fifo_in_ready)
      begin
        point_count_q <= point_count_q + 16'h0001;
        if (pt_last_q)
        begin
          dl_active_q  <= 1'b0;
          hdr_unspec_q <= !(set_seen_q || set_valid);
          short_wave_q <= (point_count_q + 16'h0001) < `IQU_MIN_POINTS;
        end
      end
    end
  end

  // Buffering
  wire        fo_valid;
  wire        fo_ready;
  wire [39:0] fo_data;

  iqu_fifo #(
    .WIDTH (`IQU_FIFO_WIDTH),
    .DEPTH (`IQU_FIFO_DEPTH),
    .AW    (`IQU_FIFO_AW)
  ) u_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (pt_valid_q),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fo_valid),
    .out_ready (fo_ready),
    .out_data  (fo_data)
  );

  // Sample divider
  localparam [`IQU_DIV_W-1:0] DIV_LAST = `IQU_DIV_CYCLES - 1;
  reg  [`IQU_DIV_W-1:0] div_q;
  wire                  smp_en;

  assign smp_en = (div_q == DIV_LAST);

  always @(posedge core_clk)
  begin
    if (reset || smp_en)
      div_q <= {`IQU_DIV_W{1'b0}};
    else
      div_q <= div_q + 1'b1;
  end

  // Playback and interpolation
  reg  [15:0] hi0_q, hi1_q, hi2_q;
  reg  [15:0] hq0_q, hq1_q, hq2_q;
  reg  [7:0]  mk1_q, mk2_q;
  reg         phase_q;
  wire        pop;
  wire [16:0] mi;
  wire [16:0] mq;

  // Playback stalls the FIFO, which stalls the byte side
  assign pop = arbitrary_waveform_playback && smp_en && !phase_q && fo_valid;
  assign fo_ready = pop;
  // Overshoot here is why a full-range input can still overload
  assign mi = sat16(interp(hi0_q, hi1_q, hi2_q, fo_data[31:16]));
  assign mq = sat16(interp(hq0_q, hq1_q, hq2_q, fo_data[15:0]));

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      hi0_q        <= 16'h0000;
      hi1_q        <= 16'h0000;
      hi2_q        <= 16'h0000;
      hq0_q        <= 16'h0000;
      hq1_q        <= 16'h0000;
      hq2_q        <= 16'h0000;
      mk1_q        <= 8'h00;
      mk2_q        <= 8'h00;
      phase_q      <= 1'b0;
      dac_valid_q  <= 1'b0;
      dac_i_q      <= 16'h0000;
      dac_q_q      <= 16'h0000;
      dac_marker_q <= 8'h00;
      overload_q   <= 1'b0;
    end
    else
    begin
      dac_valid_q <= 1'b0;
      if (pop)
      begin
        hi0_q        <= hi1_q;
        hi1_q        <= hi2_q;
        hi2_q        <= fo_data[31:16];
        hq0_q        <= hq1_q;
        hq1_q        <= hq2_q;
        hq2_q        <= fo_data[15:0];
        mk1_q        <= mk2_q;
        mk2_q        <= fo_data[39:32];
        dac_i_q      <= mi[15:0];
        dac_q_q      <= mq[15:0];
        dac_marker_q <= 8'h00;
        dac_valid_q  <= 1'b1;
        phase_q      <= 1'b1;
      end
      else if (smp_en && phase_q)
      begin
        // Real point follows its leading midpoint
        dac_i_q      <= hi1_q;
        dac_q_q      <= hq1_q;
        dac_marker_q <= mk1_q;
        dac_valid_q  <= 1'b1;
        phase_q      <= 1'b0;
      end
      // Set wins over clear so no overload is missed
      if (pop && (mi[16] || mq[16]))
        overload_q <= 1'b1;
      else if (pt_valid_q && fifo_in_ready && (si[16] || sq[16]))
        overload_q <= 1'b1;
      else if (overload_clear)
        overload_q <= 1'b0;
    end
  end

endmodule // iqu_unpacker

`default_nettype wire

// file: tb/iqu_host_model.sv
// Download path model: sends big-endian I/Q words as bytes.
// Assumes the unpacker samples on the rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module iqu_host_model (
  // Clock
  input  wire logic       core_clk,
  // Byte streams toward the unpacker
  output var  logic       in_valid,
  input  wire logic       in_ready,
  output var  logic [7:0] in_byte,
  output var  logic       in_last,
  output var  logic       q_valid,
  input  wire logic       q_ready,
  output var  logic [7:0] q_byte
);
  int timeouts = 0;
  initial
  begin
    {in_valid, q_valid, in_last} = 3'h0;
    {in_byte, q_byte} = 16'h0000;
  end
  // Ready is judged just before the edge, so the byte holds through that edge
  task automatic put(input logic lane, input logic [7:0] b, input logic last);
    int n;
    begin
      n = 0;
      @(negedge core_clk);
      in_valid = !lane;
      q_valid = lane;
      in_byte = lane ? ~in_byte : b;
      q_byte = lane ? b : ~q_byte;
      in_last = last && !lane;
      #4;
      while (!(lane ? q_ready : in_ready) && n < 300)
      begin
        @(negedge core_clk);
        #4;
        n++;
      end
      if (n == 300)
        timeouts++;
      @(posedge core_clk);
    end
  endtask
  // High byte first, I then Q; released lines show the inverse of the last byte
  task automatic send_point(input logic sp, input logic [15:0] iw, qw, input logic last);
    begin
      put(1'b0, iw[15:8], 1'b0);
      put(1'b0, iw[7:0], 1'b0);
      put(sp, qw[15:8], 1'b0);
      put(sp, qw[7:0], last);
      @(negedge core_clk);
      {in_valid, q_valid, in_last} = 3'h0;
      in_byte = ~in_byte;
      q_byte = ~q_byte;
    end
  endtask
endmodule // iqu_host_model
`default_nettype wire

// file: tb/iqu_unpacker_properties.sv
// Port-level checks for the I/Q sample unpacker.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module iqu_unpacker_properties (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Byte side
  input wire logic        split_streams,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        q_ready,
  // Playback and DAC side
  input wire logic        arbitrary_waveform_playback,
  input wire logic        overload_clear,
  input wire logic        dac_valid_q,
  input wire logic [15:0] dac_i_q,
  input wire logic [15:0] dac_q_q,
  input wire logic [7:0]  dac_marker_q,
  input wire logic        overload_q
);
  logic [1:0] byte_cnt_q;
  // Byte position within a point
  always @(posedge core_clk)
  begin
    if (reset)
      byte_cnt_q <= 2'h0;
    else if (in_valid && in_ready)
      byte_cnt_q <= byte_cnt_q + 2'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  marker_rsvd_zero_a: assert property (dac_valid_q |-> dac_marker_q[7:4] == 4'h0)
    else $error("reserved marker bits set");
  dac_pulse_gap_a: assert property (dac_valid_q |=> !dac_valid_q [*3])
    else $error("dac words closer than the sample period");
  idle_no_out_a: assert property (!arbitrary_waveform_playback [*2] |-> !dac_valid_q)
    else $error("dac word while playback off");
  dac_hold_a: assert property (!dac_valid_q |-> $stable(dac_i_q) && $stable(dac_q_q))
    else $error("dac word changed without valid");
  overload_sticky_a: assert property (overload_q && !overload_clear |=> overload_q)
    else $error("overload dropped without clear");
  point_gap_a: assert property (in_valid && in_ready && !split_streams &&
    byte_cnt_q == 2'h3 |=> !in_ready) else $error("no dead cycle after a point");
  split_excl_a: assert property (split_streams |-> !(in_ready && q_ready))
    else $error("both streams ready at once");
  q_unused_a: assert property (!split_streams |-> !q_ready)
    else $error("second stream ready while interleaved");
endmodule // iqu_unpacker_properties
bind iqu_unpacker iqu_unpacker_properties i_iqu_unpacker_properties (
  .core_clk(core_clk), .reset(reset), .split_streams(split_streams),
  .in_valid(in_valid), .in_ready(in_ready), .q_ready(q_ready),
  .arbitrary_waveform_playback(arbitrary_waveform_playback),
  .overload_clear(overload_clear), .dac_valid_q(dac_valid_q), .dac_i_q(dac_i_q),
  .dac_q_q(dac_q_q), .dac_marker_q(dac_marker_q), .overload_q(overload_q)
);
`default_nettype wire

// file: tb/tb_iqu_unpacker.sv
// Self-checking bench for the I/Q sample unpacker.
// Assumes the host model drives bytes and a queue records DAC words.
`timescale 1ns/1ps
`default_nettype none
module tb_iqu_unpacker;
  logic core_clk = 1'b0, reset = 1'b1, legacy_fmt = 1'b0, split_streams = 1'b0;
  logic set_valid = 1'b0, arbitrary_waveform_playback = 1'b1, overload_clear = 1'b0;
  logic [6:0] runtime_amplitude_scale = 7'h64;
  logic [7:0] wave_name = 8'h00, in_byte, q_byte, dac_marker_q, wave_name_q;
  logic in_valid, in_ready, in_last, q_valid, q_ready, dac_valid_q;
  logic overload_q, short_wave_q, hdr_unspec_q;
  logic [15:0] dac_i_q, dac_q_q, point_count_q;
  logic [39:0] outs[$];
  int fails = 0, samples_checked = 0;
  iqu_unpacker i_iqu_unpacker (.core_clk(core_clk), .reset(reset),
    .legacy_fmt(legacy_fmt), .split_streams(split_streams), .in_valid(in_valid),
    .in_ready(in_ready), .in_byte(in_byte), .in_last(in_last), .wave_name(wave_name),
    .q_valid(q_valid), .q_ready(q_ready), .q_byte(q_byte), .set_valid(set_valid),
    .runtime_amplitude_scale(runtime_amplitude_scale),
    .arbitrary_waveform_playback(arbitrary_waveform_playback),
    .overload_clear(overload_clear), .dac_valid_q(dac_valid_q), .dac_i_q(dac_i_q),
    .dac_q_q(dac_q_q), .dac_marker_q(dac_marker_q), .overload_q(overload_q),
    .short_wave_q(short_wave_q), .hdr_unspec_q(hdr_unspec_q),
    .wave_name_q(wave_name_q), .point_count_q(point_count_q));
  iqu_host_model i_iqu_host_model (.core_clk(core_clk), .in_valid(in_valid),
    .in_ready(in_ready), .in_byte(in_byte), .in_last(in_last), .q_valid(q_valid),
    .q_ready(q_ready), .q_byte(q_byte));
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk)
    if (dac_valid_q === 1'b1)
      outs.push_back({dac_marker_q, dac_i_q, dac_q_q});
  task automatic wrap_up();
    fails += i_iqu_host_model.timeouts;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [39:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_outs(input int n);
    int t;
    t = 0;
    while (outs.size() < n && t < 3000)
    begin
      cyc(1);
      t++;
    end
    cyc(12);
    chk("dac word count", 40'(n), 40'(outs.size()));
    if (t == 3000)
      wrap_up();
  endtask
  // Early words mix in older history and the first point may carry the scale
  // left before it, so only words past the first point's reach are compared
  task automatic chk_run(input int n, input logic [15:0] ei, eq, input logic [7:0] mk);
    wait_outs(n);
    for (int k = 8; k < n; k++)
      chk("dac word", {(k % 2) ? mk : 8'h00, ei, eq}, outs[k]);
    outs.delete();
  endtask
  task automatic burst(input int n, input logic [15:0] iw, qw);
    for (int k = 0; k < n; k++)
      i_iqu_host_model.send_point(split_streams, iw, qw, !split_streams && k == n - 1);
  endtask
  task automatic pulse_set(input logic [6:0] pct);
    runtime_amplitude_scale = pct;
    set_valid = 1'b1;
    cyc(1);
    set_valid = 1'b0;
  endtask
  task automatic t_signed();
    wave_name = 8'h5a;
    burst(8, 16'h0800, 16'hf800);
    chk_run(16, 16'h059b, 16'hfa65, 8'h00);
    chk("name", 40'h5a, 40'(wave_name_q));
    chk("count", 40'h8, 40'(point_count_q));
    chk("status", 40'h3, 40'({short_wave_q, hdr_unspec_q}));
  endtask
  task automatic t_legacy(input logic sp);
    legacy_fmt = 1'b1;
    split_streams = sp;
    burst(8, 16'h6200, 16'h9e00);
    chk_run(16, 16'h059b, 16'hfa65, 8'h09);
    legacy_fmt = 1'b0;
    split_streams = 1'b0;
  endtask
  task automatic t_overload();
    logic seen;
    logic [15:0] w;
    seen = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      w = (k % 4 == 0 || k % 4 == 3) ? 16'h8000 : 16'h7fff;
      i_iqu_host_model.send_point(1'b0, w, w, k == 7);
      // 99 percent keeps scaled points in range, so only the midpoints overload
      if (k == 0)
        pulse_set(7'h63);
    end
    wait_outs(16);
    foreach (outs[k])
      if (outs[k][31:16] === 16'h7fff)
        seen = 1'b1;
    chk("saturated midpoint", 40'h1, 40'(seen));
    chk("overload", 40'h1, 40'(overload_q));
    cyc(20);
    chk("overload held", 40'h1, 40'(overload_q));
    overload_clear = 1'b1;
    cyc(1);
    overload_clear = 1'b0;
    cyc(2);
    chk("overload cleared", 40'h0, 40'(overload_q));
    outs.delete();
  endtask
  // Far side stalls while the buffer fills, then drains to empty
  task automatic t_fill();
    arbitrary_waveform_playback = 1'b0;
    i_iqu_host_model.send_point(1'b0, 16'h0800, 16'hf800, 1'b0);
    pulse_set(7'h32);
    burst(33, 16'h0800, 16'hf800);
    cyc(5);
    chk("refused", 40'h0, 40'(in_ready));
    arbitrary_waveform_playback = 1'b1;
    chk_run(68, 16'h0401, 16'hfbff, 8'h00);
    chk("count", 40'h22, 40'(point_count_q));
    chk("status", 40'h2, 40'({short_wave_q, hdr_unspec_q}));
  endtask
  task automatic t_carry();
    wave_name = 8'ha3;
    runtime_amplitude_scale = 7'h46;
    burst(60, 16'h0800, 16'hf800);
    chk_run(120, 16'h0401, 16'hfbff, 8'h00);
    chk("status", 40'h1, 40'({short_wave_q, hdr_unspec_q}));
    chk("count", 40'h3c, 40'(point_count_q));
    chk("name", 40'ha3, 40'(wave_name_q));
  endtask
  initial
  begin
    cyc(6);
    reset = 1'b0;
    t_signed();
    t_legacy(1'b0);
    t_legacy(1'b1);
    t_overload();
    t_fill();
    t_carry();
    wrap_up();
  end
endmodule // tb_iqu_unpacker
`default_nettype wire
